/* verif/msd_decoder_assertions.sv */
// Concurrent checks on the memory space decoder ports.
`include "msd_map.vh"
`default_nettype none
module msd_decoder_checker #(
    parameter [15:0] IROM_LIMIT = 16'h2000
) (
    input wire logic        i_core_clk,
    input wire logic        i_rst,
    input wire logic        i_ext_fetch_n,
    input wire logic        i_fetch_req,
    input wire logic [15:0] i_fetch_addr,
    input wire logic        o_fetch_ext,
    input wire logic        i_acc_req,
    input wire logic [2:0]  i_acc_mode,
    input wire logic        i_acc_we,
    input wire logic [7:0]  i_acc_addr,
    input wire logic [15:0] i_acc_wptr,
    input wire logic        o_acc_busy,
    input wire logic        o_sfr_rd,
    input wire logic        o_sfr_wr,
    input wire logic [7:0]  o_sfr_addr,
    input wire logic        o_sfr_page,
    input wire logic        o_ext_req,
    input wire logic [15:0] o_ext_addr,
    input wire logic [7:0]  o_sys_ctrl
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       take;
    logic [3:0] hist;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);
    assign take = i_acc_req && !o_acc_busy;
    // Strap history; reset reads as low, like the synchroniser.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            hist <= 4'h0;
        end else begin
            hist <= {hist[2:0], i_ext_fetch_n};
        end
    end
    fetch_ext_low_a: assert property (
        i_fetch_req && hist == 4'h0 |=> o_fetch_ext)
        else $error("fetch inside with strap low");
    fetch_int_high_a: assert property (
        i_fetch_req && hist == 4'hf
        |=> o_fetch_ext == ($past(i_fetch_addr) >= IROM_LIMIT))
        else $error("fetch side wrong with strap high");
    sfr_direct_a: assert property (
        take && i_acc_mode == `MSD_M_DIRECT && !i_acc_we && i_acc_addr[7]
        && i_acc_addr != `MSD_SYSCTL_ADDR && i_acc_addr != `MSD_PSW_ADDR
        |=> ##1 o_sfr_rd && o_sfr_addr == $past(i_acc_addr, 2))
        else $error("direct upper access missed the registers");
    indir_no_sfr_a: assert property (
        take && i_acc_mode == `MSD_M_INDIRECT
        |=> (!o_sfr_rd && !o_sfr_wr) [*4])
        else $error("indirect access reached the registers");
    sfr_page_a: assert property (
        o_sfr_rd || o_sfr_wr |-> o_sfr_page ==
        (o_sfr_addr != `MSD_ACC_ADDR && o_sys_ctrl[`MSD_PAGE_BIT]))
        else $error("register page does not follow select bit");
    page_sw_only_a: assert property (
        o_sys_ctrl != $past(o_sys_ctrl)
        |-> $past(o_acc_busy) || $past(o_acc_busy, 2))
        else $error("control map changed without an access");
    external_move_instruction_wide_a: assert property (
        take && i_acc_mode == `MSD_M_MOVX16 && i_acc_wptr < `MSD_ON_CHIP_EXTENDED_RAM_BASE
        |=> ##1 o_ext_req && o_ext_addr == $past(i_acc_wptr, 2))
        else $error("wide pointer access not sent outside");
    on_chip_extended_ram_route_a: assert property (
        take && i_acc_mode == `MSD_M_MOVX16 && i_acc_wptr >= `MSD_ON_CHIP_EXTENDED_RAM_BASE
        |=> ##1 o_ext_req == !$past(o_sys_ctrl[`MSD_XEN_BIT], 2))
        else $error("extended RAM range routed wrongly");
endmodule
bind msd_decoder msd_decoder_checker #(.IROM_LIMIT(IROM_LIMIT)) u_chk (.*);
`default_nettype wire

/* verif/msd_ext_mem.sv */
// Behavioural external data memory behind a four-phase handshake.
`default_nettype none
module msd_ext_mem (
    input  wire logic        i_core_clk,
    input  wire logic        i_slow,
    input  wire logic        i_req,
    input  wire logic        i_we,
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    output var  logic        o_ack,
    output var  logic [7:0]  o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    logic [2:0] dly = 3'h0;
    initial begin
        o_ack = 1'b0;
        o_rdata = 8'h00;
    end
    always @(posedge i_core_clk) begin
        if (i_req && !o_ack && dly < (i_slow ? 3'h5 : 3'h0)) begin
            dly <= dly + 3'h1;
        end else if (i_req && !o_ack) begin
            dly <= 3'h0;
            o_ack <= 1'b1;
            o_rdata <= i_we ? ~i_wdata : mem[i_addr];
            if (i_we) begin
                mem[i_addr] <= i_wdata;
            end
        end else if (!i_req && o_ack) begin
            o_ack <= 1'b0;
            o_rdata <= ~o_rdata;
        end
    end
endmodule
`default_nettype wire

/* verif/test_msd_decoder.sv */
// Self-checking testbench for the memory space decoder.
`include "msd_map.vh"
`default_nettype none
module test_msd_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [15:0] LIM = 16'h0400;
    localparam [2:0]  DIR = `MSD_M_DIRECT;
    localparam [2:0]  IND = `MSD_M_INDIRECT;
    localparam [2:0]  BTM = `MSD_M_BIT;
    localparam [2:0]  RGM = `MSD_M_REG;
    localparam [2:0]  MX8 = `MSD_M_MOVX8;
    localparam [2:0]  MXW = `MSD_M_MOVX16;
    logic        i_core_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_ext_fetch_n = 1'b0;
    logic        i_fetch_req = 1'b0;
    logic [15:0] i_fetch_addr = 16'h0;
    logic        i_acc_req = 1'b0;
    logic [2:0]  i_acc_mode = 3'h0;
    logic        i_acc_we = 1'b0;
    logic [7:0]  i_acc_addr = 8'h0;
    logic [15:0] i_acc_wptr = 16'h0;
    logic [7:0]  i_acc_page = 8'h0;
    logic [7:0]  i_acc_wdata = 8'h0;
    logic        i_acc_wbit = 1'b0;
    logic        slow = 1'b0;
    logic [7:0]  rnd = 8'h21;
    logic [7:0]  d [0:4];
    logic [9:0]  acc_q [$];
    logic [16:0] fet_q [$];
    logic [9:0]  ea;
    logic [16:0] ef;
    int          errors = 0;
    int          num_checks = 0;
    wire         i_ext_ack, o_fetch_valid, o_fetch_ext, o_acc_busy;
    wire         o_acc_done, o_acc_rbit, o_sfr_rd, o_sfr_wr, o_sfr_page;
    wire         o_ext_req, o_ext_we;
    wire  [15:0] o_fetch_addr, o_ext_addr;
    wire  [7:0]  i_sfr_rdata, i_ext_rdata, o_acc_rdata, o_sfr_addr;
    wire  [7:0]  o_sfr_wdata, o_ext_wdata, o_psw, o_sys_ctrl;

    // Register model: page 1 scrambles, idle data is inverted.
    assign i_sfr_rdata = o_sfr_rd ? o_sfr_addr ^ (o_sfr_page ? 8'h5a : 8'h0)
                                  : ~o_sfr_addr;
    msd_decoder #(.IROM_LIMIT(LIM)) dut (.*);
    msd_ext_mem u_mem (
        .i_core_clk (i_core_clk),
        .i_slow     (slow),
        .i_req      (o_ext_req),
        .i_we       (o_ext_we),
        .i_addr     (o_ext_addr),
        .i_wdata    (o_ext_wdata),
        .o_ack      (i_ext_ack),
        .o_rdata    (i_ext_rdata)
    );
    always #4 i_core_clk = ~i_core_clk;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check(input string what, input logic [16:0] exp,
                         input logic [16:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // The address also serves as wide pointer and, high byte, as page.
    task automatic acc(input logic [2:0] m, input logic we,
                       input logic [15:0] a, input logic [7:0] wd,
                       input logic [1:0] k, input logic [7:0] ex);
        acc_q.push_back({k, ex});
        @(posedge i_core_clk);
        i_acc_req <= 1'b1;
        i_acc_mode <= m;
        i_acc_we <= we;
        i_acc_addr <= a[7:0];
        i_acc_wptr <= a;
        i_acc_page <= a[15:8];
        i_acc_wdata <= wd;
        i_acc_wbit <= wd[0];
        @(posedge i_core_clk);
        i_acc_req <= 1'b0;
        for (int n = 0; n < 80 && o_acc_done !== 1'b1; n++) begin
            @(negedge i_core_clk);
        end
        @(posedge i_core_clk);
    endtask

    task automatic wr(input logic [2:0] m, input logic [15:0] a,
                      input logic [7:0] v);
        acc(m, 1'b1, a, v, 2'd0, 8'h0);
    endtask

    task automatic rd(input logic [2:0] m, input logic [15:0] a,
                      input logic [7:0] v, input logic [1:0] k = 2'd1);
        acc(m, 1'b0, a, 8'h0, k, v);
    endtask

    task automatic fetch(input logic [15:0] a, input logic x);
        fet_q.push_back({x, a});
        @(posedge i_core_clk);
        i_fetch_req <= 1'b1;
        i_fetch_addr <= a;
    endtask

    always @(posedge i_core_clk) begin
        if (o_acc_done === 1'b1) begin
            ea = acc_q.pop_front();
            if (ea[9:8] == 2'd1) begin
                check("read byte", ea[7:0], o_acc_rdata);
            end
            if (ea[9:8] == 2'd2) begin
                check("read bit", ea[0], o_acc_rbit);
            end
        end
        if (o_fetch_valid === 1'b1) begin
            ef = fet_q.pop_front();
            check("fetch", ef, {o_fetch_ext, o_fetch_addr});
        end
    end

    initial begin
        repeat (20000) @(posedge i_core_clk);
        errors++;
        end_sim();
    end

    initial begin
        for (int i = 0; i < 5; i++) begin
            d[i] = rnd;
            rnd = lfsr(rnd);
        end
        repeat (8) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(negedge i_core_clk);
        check("status word", 8'h00, o_psw);
        check("control map", 8'h01, o_sys_ctrl);
        fetch(16'h0, 1'b1);
        fetch(LIM - 16'h1, 1'b1);
        @(posedge i_core_clk);
        i_fetch_req <= 1'b0;
        i_ext_fetch_n <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        fetch(16'h0, 1'b0);
        fetch(LIM - 16'h1, 1'b0);
        fetch(LIM, 1'b1);
        fetch(16'hffff, 1'b1);
        fetch(16'h10, 1'b0);
        @(posedge i_core_clk);
        i_fetch_req <= 1'b0;
        wr(DIR, 16'h7f, d[0]);
        rd(DIR, 16'h7f, d[0]);
        wr(RGM, 16'h0, 8'h7f);
        rd(IND, 16'h0, d[0]);
        for (int b = 0; b < 4; b++) begin
            wr(DIR, 16'hd0, 8'(b * 8));
            wr(RGM, 16'h5, 8'(8'ha0 + b));
        end
        for (int b = 0; b < 4; b++) begin
            rd(DIR, 16'(b * 8 + 5), 8'(8'ha0 + b));
        end
        wr(DIR, 16'hd0, 8'h00);
        wr(DIR, 16'h20, 8'h00);
        wr(DIR, 16'h2f, 8'h00);
        wr(BTM, 16'h00, 8'h01);
        wr(BTM, 16'h7f, 8'h01);
        rd(DIR, 16'h20, 8'h01);
        rd(DIR, 16'h2f, 8'h80);
        rd(BTM, 16'h7f, 8'h01, 2'd2);
        wr(RGM, 16'h0, 8'h90);
        wr(IND, 16'h0, d[1]);
        wr(DIR, 16'h90, ~d[1]);
        check("register write", {1'b0, 8'h90, ~d[1]},
              {1'b0, o_sfr_addr, o_sfr_wdata});
        rd(IND, 16'h0, d[1]);
        rd(DIR, 16'h90, 8'h90);
        rd(BTM, 16'h83, 8'h00, 2'd2);
        wr(DIR, 16'hb1, 8'h11);
        rd(DIR, 16'hb1, 8'h11);
        rd(BTM, 16'h83, 8'h01, 2'd2);
        rd(DIR, 16'h90, 8'hca);
        rd(DIR, 16'he0, 8'he0);
        wr(DIR, 16'hb1, 8'h01);
        slow <= 1'b1;
        wr(MXW, 16'h1234, d[2]);
        slow <= 1'b0;
        rd(MXW, 16'h1234, d[2]);
        wr(RGM, 16'h1, 8'h34);
        rd(MX8, 16'h1201, d[2]);
        wr(MXW, 16'hff10, d[3]);
        rd(MXW, 16'hff10, d[3]);
        wr(DIR, 16'hb1, 8'h00);
        wr(MXW, 16'hff10, d[4]);
        rd(MXW, 16'hff10, d[4]);
        wr(DIR, 16'hb1, 8'h01);
        rd(MXW, 16'hff10, d[3]);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(negedge i_core_clk);
        check("control map", 8'h01, o_sys_ctrl);
        rd(DIR, 16'h7f, d[0]);
        rd(MXW, 16'hff10, d[3]);
        @(posedge i_core_clk);
        check("pending", 17'h0, 17'(acc_q.size() + fet_q.size()));
        end_sim();
    end
endmodule
`default_nettype wire

/* verilog/msd_decoder.v */
// Memory space decoder: program fetch select and data access routing.
`include "msd_map.vh"
`default_nettype none

// Contract
// - Fetch select pin low sends every fetch to external program memory.
// - Pin high: internal below the limit, external at or above it.
// - Internal data uses 8-bit addresses; external data 8 or 16 bits.
// - Reset leaves internal RAM and extended RAM contents untouched.
// - Lower RAM at 00h to 7Fh, reachable directly and indirectly.
// - Bytes 20h to 2Fh hold bits 00h to 7Fh, ascending.
// - Lowest 32 bytes form four banks of eight registers, one active.
// - At 80h to FFh indirect reaches upper RAM, direct reaches SFRs.
// - SFRs at multiples of eight give bit addresses byte plus bit.
// - Alternate SPECIAL_REGISTER_AREA page has the same byte and bit addressing.
// - Page select bit 0 picks standard page, 1 the alternate; resets 0.
// - Only software changes page select; some registers ignore it.
// - Extended RAM sits at the top of external data space.
// - With extended RAM disabled its range goes to external memory.
// - External data reached through wide pointer or 8-bit pointers.
// - Status word bits 3 and 4 choose the active register bank.
// - Active bank registers by index; first two act as pointers.
module msd_decoder #(
    parameter [15:0] IROM_LIMIT = `MSD_IROM_LIMIT
) (
    input  wire        i_core_clk,
    input  wire        i_rst,
    input  wire        i_ext_fetch_n,
    input  wire        i_fetch_req,
    input  wire [15:0] i_fetch_addr,
    output reg         o_fetch_valid,
    output reg         o_fetch_ext,
    output reg  [15:0] o_fetch_addr,
    input  wire        i_acc_req,
    input  wire [2:0]  i_acc_mode,
    input  wire        i_acc_we,
    input  wire [7:0]  i_acc_addr,
    input  wire [15:0] i_acc_wptr,
    input  wire [7:0]  i_acc_page,
    input  wire [7:0]  i_acc_wdata,
    input  wire        i_acc_wbit,
    output reg         o_acc_busy,
    output reg         o_acc_done,
    output reg  [7:0]  o_acc_rdata,
    output reg         o_acc_rbit,
    output reg         o_sfr_rd,
    output reg         o_sfr_wr,
    output reg  [7:0]  o_sfr_addr,
    output reg         o_sfr_page,
    output reg  [7:0]  o_sfr_wdata,
    input  wire [7:0]  i_sfr_rdata,
    output reg         o_ext_req,
    output reg         o_ext_we,
    output reg  [15:0] o_ext_addr,
    output reg  [7:0]  o_ext_wdata,
    input  wire        i_ext_ack,
    input  wire [7:0]  i_ext_rdata,
    output reg  [7:0]  o_psw,
    output reg  [7:0]  o_sys_ctrl
);

    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_PTR   = 3'h1;
    localparam [2:0] S_ISSUE = 3'h2;
    localparam [2:0] S_RD    = 3'h3;
    localparam [2:0] S_EXT   = 3'h4;
    localparam [2:0] S_EXTW  = 3'h5;

    reg        fsel_s1_reg;
    reg        fsel_s2_reg;
    reg        ack_s1_reg;
    reg        ack_s2_reg;
    reg [2:0]  state_reg;
    reg [2:0]  mode_reg;
    reg        we_reg;
    reg [7:0]  addr_reg;
    reg [7:0]  page_reg;
    reg [7:0]  wdata_reg;
    reg        wbit_reg;
    reg [2:0]  bitidx_reg;
    reg        bitop_reg;
    reg [2:0]  tgt_reg;
    reg [15:0] xaddr_reg;
    reg        iram_en;
    reg        iram_we;
    reg [7:0]  iram_addr;
    reg [7:0]  iram_wd;
    reg        on_chip_extended_ram_en;
    reg        on_chip_extended_ram_we;
    reg [7:0]  on_chip_extended_ram_wd;
    reg [7:0]  cur_byte;
    reg [7:0]  merged;
    reg [2:0]  tgt_next;
    reg [7:0]  byte_next;
    reg [2:0]  bidx_next;
    wire [7:0] iram_q;
    wire [7:0] on_chip_extended_ram_q;
    wire [1:0] bank;
    wire       on_chip_extended_ram_hit;

    // Bank select bits of the status word.
    // One active bank.
    assign bank = {o_psw[`MSD_BANK_HI_BIT], o_psw[`MSD_BANK_LO_BIT]};

    assign on_chip_extended_ram_hit = o_sys_ctrl[`MSD_XEN_BIT] &&
                      (xaddr_reg >= `MSD_ON_CHIP_EXTENDED_RAM_BASE);

    // Program fetch selection from the synchronised strap pin.
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            fsel_s1_reg   <= 1'b0;
            fsel_s2_reg   <= 1'b0;
            ack_s1_reg    <= 1'b0;
            ack_s2_reg    <= 1'b0;
            o_fetch_valid <= 1'b0;
            o_fetch_ext   <= 1'b1;
            o_fetch_addr  <= 16'h0000;
        end else begin
            fsel_s1_reg   <= i_ext_fetch_n;
            fsel_s2_reg   <= fsel_s1_reg;
            ack_s1_reg    <= i_ext_ack;
            ack_s2_reg    <= ack_s1_reg;
            o_fetch_valid <= i_fetch_req;
            if (i_fetch_req) begin
                o_fetch_addr <= i_fetch_addr;
                o_fetch_ext  <= ~fsel_s2_reg ||
                                (i_fetch_addr >= IROM_LIMIT);
            end
        end
    end

    // Byte address and bit index of the latched request.
    always @* begin
        byte_next = addr_reg;
        bidx_next = 3'h0;
        if (mode_reg == `MSD_M_BIT) begin
            bidx_next = addr_reg[2:0];
            if (addr_reg <= `MSD_LOWER_TOP) begin
                byte_next = `MSD_BITAREA_BASE + {4'h0, addr_reg[6:3]};
            end else begin
                byte_next = {addr_reg[7:3], 3'h0};
            end
        end else if (mode_reg == `MSD_M_REG) begin
            byte_next = {3'h0, bank, addr_reg[2:0]};
        end
    end

    // Target of the latched request once the address is known.
    always @* begin
        if (mode_reg == `MSD_M_MOVX8 || mode_reg == `MSD_M_MOVX16) begin
            tgt_next = on_chip_extended_ram_hit ? `MSD_T_ON_CHIP_EXTENDED_RAM : `MSD_T_EXT;
        end else if (mode_reg == `MSD_M_INDIRECT) begin
            tgt_next = `MSD_T_IRAM;
        end else if (byte_next <= `MSD_LOWER_TOP) begin
            tgt_next = `MSD_T_IRAM;
        end else if (byte_next == `MSD_SYSCTL_ADDR ||
                     byte_next == `MSD_PSW_ADDR) begin
            tgt_next = `MSD_T_SFRL;
        end else begin
            tgt_next = `MSD_T_SFRX;
        end
    end

    // Current byte of the addressed target and its bit-merged form.
    always @* begin
        case (tgt_reg)
            `MSD_T_IRAM: cur_byte = iram_q;
            `MSD_T_ON_CHIP_EXTENDED_RAM: cur_byte = on_chip_extended_ram_q;
            `MSD_T_SFRX: cur_byte = i_sfr_rdata;
            `MSD_T_SFRL: cur_byte = (xaddr_reg[7:0] == `MSD_PSW_ADDR) ?
                                    o_psw : o_sys_ctrl;
            default:     cur_byte = 8'h00;
        endcase
        merged = cur_byte;
        merged[bitidx_reg] = wbit_reg;
    end

    // Strobes to the two on-chip memories.
    always @* begin
        iram_en   = 1'b0;
        iram_we   = 1'b0;
        iram_addr = xaddr_reg[7:0];
        iram_wd   = wdata_reg;
        on_chip_extended_ram_en   = 1'b0;
        on_chip_extended_ram_we   = 1'b0;
        on_chip_extended_ram_wd   = wdata_reg;
        case (state_reg)
            S_IDLE: begin
                iram_addr = {3'h0, bank, 2'h0, i_acc_addr[0]};
                iram_en   = i_acc_req &&
                            (i_acc_mode == `MSD_M_INDIRECT ||
                             i_acc_mode == `MSD_M_MOVX8);
            end
            S_ISSUE: begin
                // The decode pass of bit and register modes must not
                // touch memory, its address is still the raw one.
                if (mode_reg != `MSD_M_BIT && mode_reg != `MSD_M_REG) begin
                    iram_en = (tgt_next == `MSD_T_IRAM);
                    iram_we = we_reg && !bitop_reg;
                    on_chip_extended_ram_en = (tgt_next == `MSD_T_ON_CHIP_EXTENDED_RAM);
                    on_chip_extended_ram_we = we_reg;
                end
            end
            S_RD: begin
                iram_en = (tgt_reg == `MSD_T_IRAM) && we_reg && bitop_reg;
                iram_we = iram_en;
                iram_wd = merged;
            end
            default: begin
                iram_en = 1'b0;
            end
        endcase
    end

    // Access sequencer and all registered outputs except the fetch ones.
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg   <= S_IDLE;
            mode_reg    <= `MSD_M_DIRECT;
            we_reg      <= 1'b0;
            addr_reg    <= 8'h00;
            page_reg    <= 8'h00;
            wdata_reg   <= 8'h00;
            wbit_reg    <= 1'b0;
            bitidx_reg  <= 3'h0;
            bitop_reg   <= 1'b0;
            tgt_reg     <= `MSD_T_IRAM;
            xaddr_reg   <= 16'h0000;
            o_acc_busy  <= 1'b0;
            o_acc_done  <= 1'b0;
            o_acc_rdata <= 8'h00;
            o_acc_rbit  <= 1'b0;
            o_sfr_rd    <= 1'b0;
            o_sfr_wr    <= 1'b0;
            o_sfr_addr  <= 8'h00;
            o_sfr_page  <= 1'b0;
            o_sfr_wdata <= 8'h00;
            o_ext_req   <= 1'b0;
            o_ext_we    <= 1'b0;
            o_ext_addr  <= 16'h0000;
            o_ext_wdata <= 8'h00;
            o_psw       <= `MSD_PSW_RST;
            o_sys_ctrl  <= `MSD_SYSCTL_RST;
        end else begin
            o_acc_done <= 1'b0;
            o_sfr_rd   <= 1'b0;
            o_sfr_wr   <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (i_acc_req) begin
                        mode_reg   <= i_acc_mode;
                        we_reg     <= i_acc_we;
                        addr_reg   <= i_acc_addr;
                        page_reg   <= i_acc_page;
                        wdata_reg  <= i_acc_wdata;
                        wbit_reg   <= i_acc_wbit;
                        bitop_reg  <= (i_acc_mode == `MSD_M_BIT);
                        o_acc_busy <= 1'b1;
                        if (i_acc_mode == `MSD_M_INDIRECT ||
                            i_acc_mode == `MSD_M_MOVX8) begin
                            state_reg <= S_PTR;
                        end else begin
                            xaddr_reg <= (i_acc_mode == `MSD_M_MOVX16) ?
                                         i_acc_wptr :
                                         {8'h00, i_acc_addr};
                            state_reg <= S_ISSUE;
                        end
                    end
                end
                S_PTR: begin
                    // 8-bit pointer, page as high byte in MOVX8 mode, 00h for indirect.
                    xaddr_reg <= (mode_reg == `MSD_M_MOVX8) ?
                                 {page_reg, iram_q} : {8'h00, iram_q};
                    state_reg <= S_ISSUE;
                end
                S_ISSUE: begin
                    // Rewrite the address once decoded.
                    if (mode_reg == `MSD_M_BIT || mode_reg == `MSD_M_REG)
                    begin
                        xaddr_reg <= {8'h00, byte_next};
                        addr_reg  <= byte_next;
                        tgt_reg   <= tgt_next;
                        bitidx_reg <= bidx_next;
                        mode_reg  <= `MSD_M_DIRECT;
                    end else begin
                        tgt_reg <= tgt_next;
                        state_reg <= S_RD;
                        o_sfr_addr  <= xaddr_reg[7:0];
                        o_sfr_wdata <= wdata_reg;
                        // Main arith register ignores the page.
                        o_sfr_page  <= o_sys_ctrl[`MSD_PAGE_BIT] &&
                                       (xaddr_reg[7:0] != `MSD_ACC_ADDR);
                        if (tgt_next == `MSD_T_EXT) begin
                            o_ext_req   <= 1'b1;
                            o_ext_we    <= we_reg;
                            o_ext_addr  <= xaddr_reg;
                            o_ext_wdata <= wdata_reg;
                            state_reg   <= S_EXT;
                        end else if (we_reg && !bitop_reg) begin
                            state_reg  <= S_IDLE;
                            o_acc_busy <= 1'b0;
                            o_acc_done <= 1'b1;
                            o_sfr_wr   <= (tgt_next == `MSD_T_SFRX);
                            if (tgt_next == `MSD_T_SFRL) begin
                                if (xaddr_reg[7:0] == `MSD_PSW_ADDR) begin
                                    o_psw <= wdata_reg;
                                end else begin
                                    o_sys_ctrl <= wdata_reg;
                                end
                            end
                        end else begin
                            o_sfr_rd <= (tgt_next == `MSD_T_SFRX);
                        end
                    end
                end
                S_RD: begin
                    o_acc_rdata <= cur_byte;
                    o_acc_rbit  <= cur_byte[bitidx_reg];
                    o_acc_busy  <= 1'b0;
                    o_acc_done  <= 1'b1;
                    state_reg   <= S_IDLE;
                    if (we_reg && bitop_reg) begin
                        o_sfr_wdata <= merged;
                        o_sfr_wr    <= (tgt_reg == `MSD_T_SFRX);
                        if (tgt_reg == `MSD_T_SFRL) begin
                            if (xaddr_reg[7:0] == `MSD_PSW_ADDR) begin
                                o_psw <= merged;
                            end else begin
                                o_sys_ctrl <= merged;
                            end
                        end
                    end
                end
                S_EXT: begin
                    if (ack_s2_reg) begin
                        o_ext_req   <= 1'b0;
                        o_acc_rdata <= i_ext_rdata;
                        state_reg   <= S_EXTW;
                    end
                end
                S_EXTW: begin
                    if (!ack_s2_reg) begin
                        o_acc_busy <= 1'b0;
                        o_acc_done <= 1'b1;
                        state_reg  <= S_IDLE;
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    msd_ram #(.AW(`MSD_IRAM_AW)) u_iram (
        .i_core_clk (i_core_clk),
        .i_en       (iram_en),
        .i_we       (iram_we),
        .i_addr     (iram_addr),
        .i_wdata    (iram_wd),
        .o_rdata    (iram_q)
    );

    msd_ram #(.AW(`MSD_ON_CHIP_EXTENDED_RAM_AW)) u_on_chip_extended_ram (
        .i_core_clk (i_core_clk),
        .i_en       (on_chip_extended_ram_en),
        .i_we       (on_chip_extended_ram_we),
        .i_addr     (xaddr_reg[7:0]),
        .i_wdata    (on_chip_extended_ram_wd),
        .o_rdata    (on_chip_extended_ram_q)
    );

endmodule

`default_nettype wire

/* verilog/msd_map.vh */
// Address map, field positions, reset values and codes of the decoder.
`ifndef MSD_MAP_VH
`define MSD_MAP_VH

// Direct addresses of the registers handled inside the decoder, and of the main arith register.
`define MSD_SYSCTL_ADDR   8'hb1
`define MSD_PSW_ADDR      8'hd0
`define MSD_ACC_ADDR      8'he0

// Field positions.
`define MSD_XEN_BIT       0
`define MSD_PAGE_BIT      4
`define MSD_BANK_LO_BIT   3
`define MSD_BANK_HI_BIT   4

// Reset values.
`define MSD_SYSCTL_RST    8'h01
`define MSD_PSW_RST       8'h00

// Address space boundaries.
`define MSD_LOWER_TOP     8'h7f
`define MSD_BITAREA_BASE  8'h20
`define MSD_IROM_LIMIT    16'h2000
`define MSD_ON_CHIP_EXTENDED_RAM_BASE     16'hff00
`define MSD_ON_CHIP_EXTENDED_RAM_AW       8
`define MSD_IRAM_AW       8

// Access modes on i_acc_mode.
`define MSD_M_DIRECT      3'h0
`define MSD_M_INDIRECT    3'h1
`define MSD_M_BIT         3'h2
`define MSD_M_REG         3'h3
`define MSD_M_MOVX8       3'h4
`define MSD_M_MOVX16      3'h5

// Access targets.
`define MSD_T_IRAM        3'h0
`define MSD_T_SFRL        3'h1
`define MSD_T_SFRX        3'h2
`define MSD_T_ON_CHIP_EXTENDED_RAM        3'h3
`define MSD_T_EXT         3'h4

`endif

/* verilog/msd_ram.v */
// Single-port byte memory with registered read data and no content reset.
`default_nettype none

module msd_ram #(
    parameter AW = 8
) (
    input  wire          i_core_clk,
    input  wire          i_en,
    input  wire          i_we,
    input  wire [AW-1:0] i_addr,
    input  wire [7:0]    i_wdata,
    output reg  [7:0]    o_rdata
);

    reg [7:0] mem [0:(1<<AW)-1];

    // Contents survive reset; only power-up leaves them undefined.
    always @(posedge i_core_clk) begin
        if (i_en) begin
            if (i_we) begin
                mem[i_addr] <= i_wdata;
            end
            o_rdata <= mem[i_addr];
        end
    end

endmodule

`default_nettype wire
